//--- rtl/sync_output_timing_defines.svh
// Constants of the output synchronisation parameter block.
// Assumes inclusion from the package only.
`ifndef SYNC_OUTPUT_TIMING_DEFINES_SVH
`define SYNC_OUTPUT_TIMING_DEFINES_SVH
// ****************************************
// Subindex map
// ****************************************
`define SUB_ENTRY_COUNT     8'h00
`define SUB_MODE_SELECT     8'h01
`define SUB_CYCLE_PERIOD    8'h02
`define SUB_SHIFT_DELAY     8'h03
`define SUB_SUPPORTED       8'h04
`define SUB_MIN_CYCLE       8'h05
`define SUB_PAIR_SPACING    8'h06
`define SUB_MIN_SAMPLE      8'h07
`define SUB_MEASURE_CTRL    8'h08
`define SUB_MAX_OUT_DELAY   8'h09
`define SUB_MISSED_COUNT    8'h0b
`define SUB_OVERRUN_COUNT   8'h0c
`define SUB_SHORT_COUNT     8'h0d
`define SUB_LATE_FLAG       8'h20
// ****************************************
// Reset and fixed values
// ****************************************
`define RST_ENTRY_COUNT     8'h20
`define RST_MODE_SELECT     16'h0001
`define RST_CYCLE_PERIOD    32'h000f4240
`define RST_SUPPORTED       16'hc807
`define RST_MIN_CYCLE       32'h000186a0
`define RST_MEASURE_CTRL    16'h0000
// ****************************************
// Field positions, timing and commands
// ****************************************
`define SUP_FREE_RUN_BIT    0
`define SUP_SM2_BIT         1
`define SUP_DC_LSB          2
`define SUP_DYNAMIC_BIT     14
`define CLK_PERIOD_NS       32'h00000064
`define CMD_STOP            16'h0000
`define CMD_START           16'h0001
`endif

//--- rtl/sync_output_timing_pkg.sv
// Types of the output synchronisation parameter block.
// Assumes the defines header sits beside it.
package sync_output_timing_pkg;
`include "sync_output_timing_defines.svh"

    typedef enum logic [1:0] {
        MODE_FREE_RUN = 2'h0,
        MODE_SM2      = 2'h1,
        MODE_SYNC0    = 2'h2,
        MODE_SYNC1    = 2'h3
    } sync_mode_t;

    typedef struct packed {
        logic        sm2_event;
        logic        sync0_event;
        logic        sync1_event;
        logic        outputs_done;
        logic        inputs_sampled;
        logic        inputs_ready;
        logic        operational;
    } timing_events_t;

    typedef struct packed {
        logic [31:0] shift_ns;
        logic [31:0] calc_ns;
        logic [31:0] max_delay_ns;
    } input_set_t;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [7:0]  subindex;
        logic [31:0] wr_data;
    } od_req_t;

    typedef struct packed {
        sync_mode_t  mode;
        logic [31:0] cycle_ns;
        logic [31:0] shift_ns;
        logic [31:0] min_cycle_ns;
        logic [31:0] calc_ns;
        logic [31:0] min_sample_ns;
        logic [31:0] max_delay_ns;
        input_set_t  in_set;
        logic [15:0] cmd;
        logic [15:0] missed;
        logic [15:0] overrun;
        logic [15:0] short_cnt;
        logic        late;
        logic [31:0] t_sync0;
        logic [31:0] t_sync1;
        logic [31:0] t_start;
        logic [31:0] t_local;
        logic [31:0] t_sample;
        logic        seen0;
        logic        seen1;
        logic        sm_seen;
        logic        out_pend;
        logic        tick;
        logic [31:0] rd_data;
        logic        rd_valid;
        logic        wr_err;
    } state_t;
endpackage

//--- rtl/sync_output_timing_params.sv
// Output synchronisation parameter block with cycle time measurement.
// Assumes event inputs are one-cycle pulses synchronous to core_clk.
// Notes on behaviour
// - Entry count subindex reads 0x20.
// - Mode 0 free run, 1 SM2 event, 2 SYNC0, 3 SYNC1; default 1.
// - Cycle time in ns sets timer, master or SYNC period; default 1000000.
// - Read-only shift time: SYNC0 to outputs driven, DC mode only.
// - Supported modes bit field reads 0xc807.
// - Minimum cycle time read-only in ns, default 100000.
// - Calc-and-copy gives needed SYNC0 to SYNC1 spacing, DC mode only.
// - Minimum delay: SYNC1 to input sampling, DC mode only.
// - Command 1 starts local cycle measurement, 0 stops it.
// - While measuring, timing entries of both sets keep largest values.
// - Starting a measurement clears previously captured maxima.
// - Maximum delay: SYNC1 to outputs driven, DC mode only.
// - Counter of missed SM events in operational state, DC mode.
// - Counter of late cycle completion or early next cycle.
// - Counter of too short SYNC0 to SYNC1 intervals, DC mode.
// - Late output flag for most recent cycle, DC mode, resets false.
`timescale 1ns/1ns
module sync_output_timing_params
    import sync_output_timing_pkg::*;
(
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           nrst,
    // Object dictionary access
    input  wire od_req_t        od_req,
    output logic [31:0]         od_rd_data,
    output logic                od_rd_valid,
    output logic                od_wr_err,
    // Timing events
    input  wire timing_events_t ev,
    // Cycle start to application
    output logic                cycle_tick,
    // Input side measured values
    output input_set_t          in_set
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    function automatic logic [31:0] run(input logic [31:0] v);
        logic [32:0] s;
        s = {1'b0, v} + {1'b0, `CLK_PERIOD_NS};
        run = s[32] ? 32'hffffffff : s[31:0];
    endfunction

    function automatic logic [31:0] maxv(input logic [31:0] a,
                                         input logic [31:0] b);
        maxv = (b > a) ? b : a;
    endfunction

    state_t q;
    state_t d;
    logic   is_dc;
    logic   start;
    logic   local_wrap;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.rd_valid = 1'b0;
        d.wr_err = 1'b0;
        is_dc = (q.mode == MODE_SYNC0) || (q.mode == MODE_SYNC1);
        local_wrap = (run(q.t_local) >= q.cycle_ns);
        unique case (q.mode)
            MODE_FREE_RUN: start = local_wrap;
            MODE_SM2:      start = ev.sm2_event;
            MODE_SYNC0:    start = ev.sync0_event;
            MODE_SYNC1:    start = ev.sync1_event;
        endcase
        d.tick = start;

        // Running timers since each reference event
        d.t_local = local_wrap ? 32'h0 : run(q.t_local);
        d.t_sync0 = ev.sync0_event ? 32'h0 : run(q.t_sync0);
        d.t_sync1 = ev.sync1_event ? 32'h0 : run(q.t_sync1);
        d.t_start = start ? 32'h0 : run(q.t_start);
        d.t_sample = ev.inputs_sampled ? 32'h0 : run(q.t_sample);
        if (ev.sync0_event) begin
            d.seen0 = 1'b1;
        end
        if (ev.sync1_event) begin
            d.seen1 = 1'b1;
        end

        // Missed SM event between two SYNC0 events
        if (ev.sm2_event) begin
            d.sm_seen = 1'b1;
        end
        if (ev.sync0_event) begin
            d.sm_seen = ev.sm2_event;
            if (is_dc && ev.operational && q.seen0 && !q.sm_seen) begin
                d.missed = sat_inc(q.missed);
            end
        end

        // Short SYNC0 to SYNC1 spacing
        if (ev.sync1_event && is_dc && q.seen0 && !ev.sync0_event
            && (q.t_sync0 < q.calc_ns)) begin
            d.short_cnt = sat_inc(q.short_cnt);
        end

        // Cycle completion and overrun
        if (ev.outputs_done) begin
            d.out_pend = 1'b0;
        end
        if (start) begin
            d.out_pend = 1'b1;
            if (ev.operational && q.out_pend && !ev.outputs_done) begin
                d.overrun = sat_inc(q.overrun);
            end
            if (is_dc) begin
                d.late = q.out_pend && !ev.outputs_done;
            end
        end

        // Measurement of dynamic times
        if (q.cmd == `CMD_START) begin
            if (ev.outputs_done) begin
                d.min_cycle_ns = maxv(q.min_cycle_ns, q.t_start);
                if (is_dc) begin
                    d.shift_ns = maxv(q.shift_ns, q.t_sync0);
                    d.calc_ns = maxv(q.calc_ns, q.t_start);
                    if (q.seen1) begin
                        d.max_delay_ns = maxv(q.max_delay_ns,
                                              q.t_sync1);
                    end
                end
            end
            if (ev.inputs_sampled && is_dc) begin
                d.in_set.shift_ns = maxv(q.in_set.shift_ns,
                                         q.t_sync0);
                if (q.seen1) begin
                    d.min_sample_ns = maxv(q.min_sample_ns, q.t_sync1);
                    d.in_set.max_delay_ns = maxv(q.in_set.max_delay_ns,
                                                 q.t_sync1);
                end
            end
            if (ev.inputs_ready && is_dc) begin
                d.in_set.calc_ns = maxv(q.in_set.calc_ns,
                                        q.t_sample);
            end
        end

        // Writes
        if (od_req.wr_en) begin
            unique case (od_req.subindex)
                `SUB_MODE_SELECT: begin
                    if (od_req.wr_data[31:2] == 30'h0) begin
                        d.mode = sync_mode_t'(od_req.wr_data[1:0]);
                    end else begin
                        d.wr_err = 1'b1;
                    end
                end
                `SUB_CYCLE_PERIOD: begin
                    d.cycle_ns = od_req.wr_data;
                end
                `SUB_MEASURE_CTRL: begin
                    if (od_req.wr_data == {16'h0, `CMD_START}) begin
                        d.cmd = `CMD_START;
                        if (q.cmd != `CMD_START) begin
                            d.shift_ns = 32'h0;
                            d.min_cycle_ns = 32'h0;
                            d.calc_ns = 32'h0;
                            d.min_sample_ns = 32'h0;
                            d.max_delay_ns = 32'h0;
                            d.in_set = '0;
                        end
                    end else if (od_req.wr_data == {16'h0, `CMD_STOP}) begin
                        d.cmd = `CMD_STOP;
                    end else begin
                        d.wr_err = 1'b1;
                    end
                end
                default: d.wr_err = 1'b1;
            endcase
        end

        // Reads
        if (od_req.rd_en) begin
            d.rd_valid = 1'b1;
            unique case (od_req.subindex)
                `SUB_ENTRY_COUNT:   d.rd_data = {24'h0, `RST_ENTRY_COUNT};
                `SUB_MODE_SELECT:   d.rd_data = {30'h0, q.mode};
                `SUB_CYCLE_PERIOD:  d.rd_data = q.cycle_ns;
                `SUB_SHIFT_DELAY:   d.rd_data = q.shift_ns;
                `SUB_SUPPORTED:     d.rd_data = {16'h0, `RST_SUPPORTED};
                `SUB_MIN_CYCLE:     d.rd_data = q.min_cycle_ns;
                `SUB_PAIR_SPACING:  d.rd_data = q.calc_ns;
                `SUB_MIN_SAMPLE:    d.rd_data = q.min_sample_ns;
                `SUB_MEASURE_CTRL:  d.rd_data = {16'h0, q.cmd};
                `SUB_MAX_OUT_DELAY: d.rd_data = q.max_delay_ns;
                `SUB_MISSED_COUNT:  d.rd_data = {16'h0, q.missed};
                `SUB_OVERRUN_COUNT: d.rd_data = {16'h0, q.overrun};
                `SUB_SHORT_COUNT:   d.rd_data = {16'h0, q.short_cnt};
                `SUB_LATE_FLAG:     d.rd_data = {31'h0, q.late};
                default:            d.rd_data = 32'h0;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.mode <= MODE_SM2;
            q.cycle_ns <= `RST_CYCLE_PERIOD;
            q.min_cycle_ns <= `RST_MIN_CYCLE;
            q.cmd <= `RST_MEASURE_CTRL;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign od_rd_data = q.rd_data;
    assign od_rd_valid = q.rd_valid;
    assign od_wr_err = q.wr_err;
    assign cycle_tick = q.tick;
    assign in_set = q.in_set;
endmodule

//--- tb/sync_output_timing_sva.sv
// Checker of the output synchronisation parameter block.
// Assumes a bind onto the block's top module ports.
`timescale 1ns/1ns
module sync_output_timing_sva
    import sync_output_timing_pkg::*;
(
    // Clock and reset
    input wire logic           core_clk,
    input wire logic           nrst,
    // Access port
    input wire od_req_t        od_req,
    input wire logic [31:0]    od_rd_data,
    input wire logic           od_rd_valid,
    input wire logic           od_wr_err,
    // Events
    input wire timing_events_t ev,
    input wire logic           cycle_tick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    rd_answer_a: assert property (od_req.rd_en |=> od_rd_valid)
        else $error("read without answer");
    rd_hold_a: assert property (!od_req.rd_en |=> !od_rd_valid
        && $stable(od_rd_data))
        else $error("read data moved without read");
    entry_count_a: assert property (od_req.rd_en && od_req.subindex == 8'h00
        |=> od_rd_data == 32'h00000020)
        else $error("entry count wrong");
    supported_a: assert property (od_req.rd_en && od_req.subindex == 8'h04
        |=> od_rd_data == 32'h0000c807)
        else $error("supported modes wrong");
    ro_refuse_a: assert property (od_req.wr_en && od_req.subindex inside
        {8'h03, 8'h05, 8'h06, 8'h07, 8'h09} |=> od_wr_err)
        else $error("read-only write accepted");
    mode_range_a: assert property (od_req.wr_en && od_req.subindex == 8'h01
        |=> od_wr_err == ($past(od_req.wr_data) > 32'h3))
        else $error("mode refusal wrong");
    cmd_range_a: assert property (od_req.wr_en && od_req.subindex == 8'h08
        |=> od_wr_err == ($past(od_req.wr_data) > 32'h1))
        else $error("command refusal wrong");
    no_err_a: assert property (!od_req.wr_en |=> !od_wr_err)
        else $error("error without write");
    c_read: cover property (od_req.rd_en ##1 od_rd_valid);
    c_refuse: cover property (od_req.wr_en ##1 od_wr_err);
    c_tick: cover property (ev.sync0_event ##1 cycle_tick);
endmodule

//--- tb/od_master_model.sv
// Bus master model issuing object dictionary reads and writes.
// Assumes tasks are called from the bench, one at a time.
`timescale 1ns/1ns
module od_master_model
    import sync_output_timing_pkg::*;
(
    // Clock
    input  wire logic        core_clk,
    // Object dictionary access
    output od_req_t          od_req,
    input  wire logic [31:0] od_rd_data,
    input  wire logic        od_rd_valid,
    input  wire logic        od_wr_err
);
    initial od_req = '0;
    // One strobe cycle, then idle lines show inverted values
    task automatic issue(input logic w, input logic [7:0] s,
                         input logic [31:0] d);
        @(posedge core_clk);
        #1;
        od_req = '{wr_en: w, rd_en: !w, subindex: s, wr_data: d};
        @(posedge core_clk);
        #1;
        od_req = '{wr_en: 1'b0, rd_en: 1'b0, subindex: ~s, wr_data: ~d};
    endtask
    task automatic wr(input logic [7:0] s, input logic [31:0] d,
                      output logic err);
        issue(1'b1, s, d);
        err = od_wr_err;
    endtask
    task automatic rd(input logic [7:0] s, output logic [31:0] d);
        issue(1'b0, s, $urandom);
        d = (od_rd_valid === 1'b1) ? od_rd_data : 'x;
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench of the output synchronisation parameter block.
// Assumes the master model and checker are compiled beforehand.
`timescale 1ns/1ns
module testbench;
    import sync_output_timing_pkg::*;
    logic           core_clk;
    logic           nrst;
    od_req_t        od_req;
    logic [31:0]    od_rd_data;
    logic           od_rd_valid;
    logic           od_wr_err;
    timing_events_t ev;
    logic           cycle_tick;
    input_set_t     in_set;
    int             failures;
    int             total_checks;
    logic [31:0]    rv;
    logic [31:0]    base;
    logic           er;
    int unsigned    g;
    logic [7:0]     subs [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h20};
    logic [31:0]    rsts [15] = '{32'h20, 32'h1, 32'hf4240, 32'h0, 32'hc807,
        32'h186a0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0};

    sync_output_timing_params i_sync_output_timing_params (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .od_req      (od_req),
        .od_rd_data  (od_rd_data),
        .od_rd_valid (od_rd_valid),
        .od_wr_err   (od_wr_err),
        .ev          (ev),
        .cycle_tick  (cycle_tick),
        .in_set      (in_set)
    );
    od_master_model i_od_master_model (
        .core_clk    (core_clk),
        .od_req      (od_req),
        .od_rd_data  (od_rd_data),
        .od_rd_valid (od_rd_valid),
        .od_wr_err   (od_wr_err)
    );

    always #50 core_clk = ~core_clk;

    function automatic logic [31:0] gap(input int unsigned n);
        return (n + 1) * 100;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] s,
                          input logic [31:0] exp);
        i_od_master_model.rd(s, rv);
        check(what, rv, exp);
    endtask
    task automatic wr_chk(input logic [7:0] s, input logic [31:0] d,
                          input logic exp);
        i_od_master_model.wr(s, d, er);
        check("write refusal", 32'(er), 32'(exp));
    endtask
    // Event k: 0 sm2, 1 sync0, 2 sync1, 3 outputs done
    task automatic pulse(input int k, input logic tick);
        timing_events_t m;
        m = timing_events_t'(7'h40 >> k);
        @(posedge core_clk);
        #1;
        ev = ev | m;
        @(posedge core_clk);
        #1;
        ev = ev & ~m;
        if (tick) check("cycle tick", 32'(cycle_tick), 32'h1);
    endtask
    task automatic cyc(input int unsigned n, input logic sm);
        if (sm) pulse(0, 1'b0);
        pulse(1, 1'b1);
        repeat (n) @(posedge core_clk);
        pulse(3, 1'b0);
    endtask

    initial begin
        #2000000;
        failures++;
        finish_test();
    end

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        ev = '0;
        failures = 0;
        total_checks = 0;
        void'($urandom(70));
        repeat (12) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        for (int i = 0; i < 15; i++) begin
            rd_chk("reset value", subs[i], rsts[i]);
        end
        wr_chk(8'h03, 32'h1, 1'b1);
        g = 32'h186a0 + $urandom % 32'h100000;
        wr_chk(8'h02, g, 1'b0);
        rd_chk("cycle time", 8'h02, g);
        for (int m = 0; m < 4; m++) begin
            wr_chk(8'h01, m, 1'b0);
            rd_chk("mode", 8'h01, m);
            if (m > 0) pulse(m - 1, 1'b1);
        end
        wr_chk(8'h01, 4 + $urandom % 8, 1'b1);
        rd_chk("mode kept", 8'h01, 32'h3);
        wr_chk(8'h01, 32'h2, 1'b0);
        ev.operational = 1'b1;
        wr_chk(8'h08, 32'h2, 1'b1);
        wr_chk(8'h08, 32'h1, 1'b0);
        g = 2 + $urandom % 19;
        cyc(g, 1'b1);
        rd_chk("shift", 8'h03, gap(g));
        rd_chk("min cycle", 8'h05, gap(g));
        rd_chk("calc", 8'h06, gap(g));
        cyc(g - 1, 1'b1);
        rd_chk("shift max", 8'h03, gap(g));
        i_od_master_model.rd(8'h0b, base);
        cyc(2, 1'b1);
        rd_chk("missed with sm2", 8'h0b, base);
        cyc(2, 1'b0);
        rd_chk("missed", 8'h0b, base + 1);
        i_od_master_model.rd(8'h0c, base);
        pulse(1, 1'b1);
        cyc(2, 1'b1);
        rd_chk("overrun", 8'h0c, base + 1);
        rd_chk("late", 8'h20, 32'h1);
        pulse(1, 1'b1);
        rd_chk("late clear", 8'h20, 32'h0);
        pulse(1, 1'b1);
        pulse(2, 1'b0);
        rd_chk("short", 8'h0d, 32'h1);
        pulse(1, 1'b1);
        pulse(2, 1'b0);
        pulse(4, 1'b0);
        pulse(5, 1'b0);
        check("input shift", in_set.shift_ns, 32'h12c);
        check("input delay", in_set.max_delay_ns, 32'h64);
        check("input calc", in_set.calc_ns, 32'h64);
        rd_chk("min delay", 8'h07, 32'h64);
        wr_chk(8'h08, 32'h0, 1'b0);
        cyc(g + 5, 1'b1);
        rd_chk("stopped", 8'h03, gap(g));
        wr_chk(8'h08, 32'h1, 1'b0);
        rd_chk("shift cleared", 8'h03, 32'h0);
        rd_chk("min cycle cleared", 8'h05, 32'h0);
        check("input shift cleared", in_set.shift_ns, 32'h0);
        wr_chk(8'h02, 32'h12c, 1'b0);
        wr_chk(8'h01, 32'h0, 1'b0);
        repeat (3) @(posedge core_clk);
        g = 0;
        repeat (30) begin
            @(posedge core_clk);
            #1;
            g += cycle_tick;
        end
        check("free run ticks", g, 32'ha);
        finish_test();
    end
endmodule

bind sync_output_timing_params sync_output_timing_sva i_sync_output_timing_sva (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .od_req      (od_req),
    .od_rd_data  (od_rd_data),
    .od_rd_valid (od_rd_valid),
    .od_wr_err   (od_wr_err),
    .ev          (ev),
    .cycle_tick  (cycle_tick)
);
